// >>> src/nrg_timers.sv
// Added by the designer: the Wishbone interface to the registers.
`timescale 1ns/1ps

`include "nrg_map.svh"

module nrg_timers (
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic [7:0]       adr_i,
    input  wire logic [31:0]      dat_i,
    output logic      [31:0]      dat_o,
    input  wire logic             we_i,
    input  wire logic [3:0]       sel_i,
    input  wire logic             cyc_i,
    input  wire logic             stb_i,
    output logic                  ack_o,
    input  wire logic             carrier_tick_i,
    input  wire nrg_pkg::nrg_evt_t evt_i,
    output logic                  irq_o,
    output logic                  field_off_o,
    output logic                  nrt_running_o,
    output logic                  gpt_running_o
);

    // ****************
    // register bus
    // ****************
    logic [5:0]            index;
    logic                  take;
    logic [31:0]           next_rdata;
    logic [7:0]            nrt_high;
    logic [7:0]            nrt_low;
    nrg_pkg::nrg_ctrl_t    ctrl;
    logic [7:0]            gpt_high;
    logic [7:0]            gpt_low;
    logic [7:0]            irq_mask;
    logic [7:0]            irq_status;
    logic [7:0]            mode;
    logic                  cmd_nrt;
    logic                  cmd_gpt;
    logic                  cmd_default;

    nrg_pkg::nrg_nrt_state_t nrt_state;

    function automatic logic wr_hit(input logic [5:0] idx);
        wr_hit = take && we_i && sel_i[0] && index == idx;
    endfunction

    assign index = adr_i[7:2];
    // a write lands only on the edge where the master sees ack
    assign take  = cyc_i && stb_i && ack_o;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= cyc_i && stb_i && !ack_o;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (index)
            `NRG_IDX_NRT_HIGH:   next_rdata[7:0] = nrt_high;
            `NRG_IDX_NRT_LOW:    next_rdata[7:0] = nrt_low;
            `NRG_IDX_TIMER_CTRL: next_rdata[7:0] = ctrl;
            `NRG_IDX_GPT_HIGH:   next_rdata[7:0] = gpt_high;
            `NRG_IDX_GPT_LOW:    next_rdata[7:0] = gpt_low;
            `NRG_IDX_IRQ_MASK:   next_rdata[7:0] = irq_mask;
            `NRG_IDX_IRQ_STATUS: next_rdata[7:0] = irq_status;
            `NRG_IDX_MODE:       next_rdata[7:0] = mode;
            `NRG_IDX_STATE: begin
                next_rdata[`NRG_ST_NRT_RUN_BIT]  = nrt_running_o;
                next_rdata[`NRG_ST_NRT_WAIT_BIT] =
                    (nrt_state == nrg_pkg::NRG_NRT_WAIT_FIELD);
                next_rdata[`NRG_ST_GPT_RUN_BIT]  = gpt_running_o;
            end
            default:             next_rdata = 32'h0000_0000;
        endcase
    end

    // unmapped indices answer with zero data and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (cyc_i && stb_i && !ack_o) begin
            dat_o <= next_rdata;
        end
    end

    // ****************
    // commands: write-one pulses, the command register reads as zero
    // ****************
    assign cmd_nrt     = wr_hit(`NRG_IDX_COMMAND) && dat_i[`NRG_CMD_NRT_BIT];
    assign cmd_gpt     = wr_hit(`NRG_IDX_COMMAND) && dat_i[`NRG_CMD_GPT_BIT];
    assign cmd_default = wr_hit(`NRG_IDX_COMMAND)
                         && dat_i[`NRG_CMD_DEFAULT_BIT];

    // ****************
    // configuration registers
    // ****************
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_default) begin
            nrt_high <= `NRG_RST_NRT_HIGH;
            nrt_low  <= `NRG_RST_NRT_LOW;
            ctrl     <= `NRG_RST_TIMER_CTRL;
            gpt_high <= `NRG_RST_GPT_HIGH;
            gpt_low  <= `NRG_RST_GPT_LOW;
            irq_mask <= `NRG_RST_IRQ_MASK;
            mode     <= `NRG_RST_MODE;
        end else begin
            if (wr_hit(`NRG_IDX_NRT_HIGH)) begin
                nrt_high <= dat_i[7:0];
            end
            if (wr_hit(`NRG_IDX_NRT_LOW)) begin
                nrt_low <= dat_i[7:0];
            end
            if (wr_hit(`NRG_IDX_TIMER_CTRL)) begin
                // reserved bits 4..2 stay zero
                ctrl <= {dat_i[7:5], 3'h0, dat_i[1:0]};
            end
            if (wr_hit(`NRG_IDX_GPT_HIGH)) begin
                gpt_high <= dat_i[7:0];
            end
            if (wr_hit(`NRG_IDX_GPT_LOW)) begin
                gpt_low <= dat_i[7:0];
            end
            if (wr_hit(`NRG_IDX_IRQ_MASK)) begin
                irq_mask <= dat_i[7:0] & 8'h60;
            end
            if (wr_hit(`NRG_IDX_MODE)) begin
                mode <= dat_i[7:0] & 8'h03;
            end
        end
    end

    // ****************
    // no-response timer
    // ****************
    logic [15:0]             nrt_value;
    logic                    nfc_mode;
    logic                    nrt_auto;
    logic                    nrt_start;
    logic                    nrt_stop;
    logic                    nrt_step;
    logic                    nrt_expire;
    logic [11:0]             nrt_period_m1;

    assign nrt_value = {nrt_high, nrt_low};
    assign nfc_mode  = mode[`NRG_MODE_NFC_BIT];
    // active peer-to-peer waits for the transmitter to drop, not tx end
    assign nrt_auto  = mode[`NRG_MODE_P2P_BIT] ? evt_i.tx_off
                                               : evt_i.tx_end;
    // payment mode ignores a bare start of reception, since noise
    // bursts must not cancel the timeout; only a complete frame does
    assign nrt_stop  = ctrl.pay_mode ? evt_i.rx_end
                                     : evt_i.rx_start;

    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_default) begin
            nrt_state <= nrg_pkg::NRG_NRT_IDLE;
        end else begin
            case (nrt_state)
                nrg_pkg::NRG_NRT_IDLE: begin
                    if (cmd_nrt && nrt_value != 16'h0000) begin
                        nrt_state <= nrg_pkg::NRG_NRT_COUNT;
                    end else if (nrt_auto && nrt_value != 16'h0000) begin
                        if (nfc_mode && !evt_i.ext_field) begin
                            nrt_state <= nrg_pkg::NRG_NRT_WAIT_FIELD;
                        end else begin
                            nrt_state <= nrg_pkg::NRG_NRT_COUNT;
                        end
                    end
                end
                nrg_pkg::NRG_NRT_WAIT_FIELD: begin
                    if (cmd_nrt || evt_i.ext_field) begin
                        nrt_state <= nrg_pkg::NRG_NRT_COUNT;
                    end else if (nrt_stop) begin
                        nrt_state <= nrg_pkg::NRG_NRT_IDLE;
                    end
                end
                nrg_pkg::NRG_NRT_COUNT: begin
                    if (cmd_nrt) begin
                        nrt_state <= nrg_pkg::NRG_NRT_COUNT;
                    end else if (nrt_stop || nrt_expire) begin
                        nrt_state <= nrg_pkg::NRG_NRT_IDLE;
                    end
                end
                default: nrt_state <= nrg_pkg::NRG_NRT_IDLE;
            endcase
        end
    end

    // start pulse to the counter mirrors the transitions above
    always_comb begin
        nrt_start = 1'b0;
        case (nrt_state)
            nrg_pkg::NRG_NRT_IDLE:
                nrt_start = cmd_nrt
                            || (nrt_auto && !(nfc_mode
                                && !evt_i.ext_field));
            nrg_pkg::NRG_NRT_WAIT_FIELD:
                nrt_start = cmd_nrt || evt_i.ext_field;
            nrg_pkg::NRG_NRT_COUNT:
                nrt_start = cmd_nrt;
            default:
                nrt_start = 1'b0;
        endcase
    end

    assign nrt_period_m1 = ctrl.long_step
                           ? 12'(`NRG_FC_PER_NRT_LONG - 1)
                           : 12'(`NRG_FC_PER_NRT_STEP - 1);

    nrg_step_gen u_nrt_step (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .restart_i      (nrt_start),
        .carrier_tick_i (carrier_tick_i),
        .period_m1_i    (nrt_period_m1),
        .step_o         (nrt_step)
    );

    nrg_down_timer u_nrt (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (nrt_start && !cmd_default),
        .stop_i    (cmd_default || (nrt_stop && !cmd_nrt)),
        .value_i   (nrt_value),
        .step_i    (nrt_step),
        .running_o (nrt_running_o),
        .expire_o  (nrt_expire)
    );

    // ****************
    // general-purpose timer
    // ****************
    logic        gpt_trig;
    logic        gpt_start;
    logic        gpt_step;
    logic        gpt_expire;
    logic        gpt_kill_field;
    logic [15:0] gpt_value;

    assign gpt_value = {gpt_high, gpt_low};

    always_comb begin
        gpt_trig = 1'b0;
        case (ctrl.trigger)
            `NRG_TRIG_NONE:       gpt_trig = 1'b0;
            `NRG_TRIG_RX_END:     gpt_trig = evt_i.rx_end;
            `NRG_TRIG_RX_START:   gpt_trig = evt_i.rx_start;
            `NRG_TRIG_TX_END_NFC: gpt_trig = evt_i.tx_end && nfc_mode;
            default:              gpt_trig = 1'b0;
        endcase
    end

    assign gpt_start = cmd_gpt || gpt_trig;

    // the field-off duty is fixed at start so a later trigger change
    // cannot cancel or invent a field switch-off
    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_default) begin
            gpt_kill_field <= 1'b0;
        end else if (gpt_start) begin
            gpt_kill_field <= (ctrl.trigger == `NRG_TRIG_TX_END_NFC);
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            field_off_o <= 1'b0;
        end else begin
            field_off_o <= gpt_expire && gpt_kill_field;
        end
    end

    nrg_step_gen u_gpt_step (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .restart_i      (gpt_start),
        .carrier_tick_i (carrier_tick_i),
        .period_m1_i    (12'(`NRG_FC_PER_GPT_STEP - 1)),
        .step_o         (gpt_step)
    );

    nrg_down_timer u_gpt (
        .clk_i     (clk_i),
        .rst_i     (rst_i),
        .start_i   (gpt_start && !cmd_default),
        .stop_i    (cmd_default),
        .value_i   (gpt_value),
        .step_i    (gpt_step),
        .running_o (gpt_running_o),
        .expire_o  (gpt_expire)
    );

    // ****************
    // interrupt status, write one to clear, a new event wins
    // ****************
    logic [7:0] irq_set;
    logic [7:0] irq_clr;

    always_comb begin
        irq_set = 8'h00;
        irq_set[`NRG_IRQ_NRT_BIT] = nrt_expire;
        irq_set[`NRG_IRQ_GPT_BIT] = gpt_expire;
    end

    assign irq_clr = wr_hit(`NRG_IDX_IRQ_STATUS) ? dat_i[7:0] : 8'h00;

    always_ff @(posedge clk_i) begin
        if (rst_i || cmd_default) begin
            irq_status <= 8'h00;
        end else begin
            irq_status <= (irq_status & ~irq_clr) | irq_set;
        end
    end

    // a set mask bit blocks that source
    assign irq_o = |(irq_status & ~irq_mask & 8'h60);

endmodule // nrg_timers

// >>> shared/nrg_map.svh
`ifndef NRG_MAP_SVH
`define NRG_MAP_SVH

// ****************
// register indices (byte address = index * 4)
// ****************
`define NRG_IDX_NRT_HIGH     6'h0F
`define NRG_IDX_NRT_LOW      6'h10
`define NRG_IDX_TIMER_CTRL   6'h11
`define NRG_IDX_GPT_HIGH     6'h12
`define NRG_IDX_GPT_LOW      6'h13
`define NRG_IDX_IRQ_MASK     6'h15
`define NRG_IDX_IRQ_STATUS   6'h18
`define NRG_IDX_MODE         6'h1A
`define NRG_IDX_COMMAND      6'h1B
`define NRG_IDX_STATE        6'h1C

// ****************
// reset values
// ****************
`define NRG_RST_NRT_HIGH     8'h00
`define NRG_RST_NRT_LOW      8'h00
`define NRG_RST_TIMER_CTRL   8'h00
`define NRG_RST_GPT_HIGH     8'h00
`define NRG_RST_GPT_LOW      8'h00
`define NRG_RST_IRQ_MASK     8'h00
`define NRG_RST_MODE         8'h00

// ****************
// field positions
// ****************
`define NRG_CTRL_STEP_BIT    0
`define NRG_CTRL_PAY_BIT     1
`define NRG_CTRL_TRIG_LSB    5
`define NRG_CTRL_TRIG_MSB    7
`define NRG_IRQ_GPT_BIT      5
`define NRG_IRQ_NRT_BIT      6
`define NRG_MODE_NFC_BIT     0
`define NRG_MODE_P2P_BIT     1
`define NRG_CMD_NRT_BIT      0
`define NRG_CMD_GPT_BIT      1
`define NRG_CMD_DEFAULT_BIT  2
`define NRG_ST_NRT_RUN_BIT   0
`define NRG_ST_NRT_WAIT_BIT  1
`define NRG_ST_GPT_RUN_BIT   2

// ****************
// trigger codes
// ****************
`define NRG_TRIG_NONE        3'h0
`define NRG_TRIG_RX_END      3'h1
`define NRG_TRIG_RX_START    3'h2
`define NRG_TRIG_TX_END_NFC  3'h3

// ****************
// timing: carrier periods per step
// ****************
`define NRG_FC_PER_NRT_STEP  64
`define NRG_FC_PER_NRT_LONG  4096
`define NRG_FC_PER_GPT_STEP  8

`endif

// >>> shared/nrg_pkg.sv
package nrg_pkg;

    // ****************************************************************
    // front-end events, each a one-cycle pulse except ext_field
    // ****************************************************************
    typedef struct packed {
        logic tx_end;
        logic tx_off;
        logic rx_start;
        logic rx_end;
        logic ext_field;
    } nrg_evt_t;

    typedef struct packed {
        logic [2:0] trigger;
        logic [2:0] unused;
        logic       pay_mode;
        logic       long_step;
    } nrg_ctrl_t;

    typedef enum logic [1:0] {
        NRG_NRT_IDLE,
        NRG_NRT_WAIT_FIELD,
        NRG_NRT_COUNT
    } nrg_nrt_state_t;

endpackage

// >>> src/nrg_step_gen.sv
`timescale 1ns/1ps

// ********************************************************************
// carrier prescaler: one tick every period_m1_i+1 carrier ticks
// ********************************************************************
module nrg_step_gen (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        restart_i,
    input  wire logic        carrier_tick_i,
    input  wire logic [11:0] period_m1_i,
    output logic             step_o
);

    logic [11:0] count;

    // restart realigns so the first step after a start is a full one
    always_ff @(posedge clk_i) begin
        if (rst_i || restart_i) begin
            count <= 12'h000;
        end else if (carrier_tick_i) begin
            if (count >= period_m1_i) begin
                count <= 12'h000;
            end else begin
                count <= count + 12'h001;
            end
        end
    end

    assign step_o = carrier_tick_i && !restart_i && (count >= period_m1_i);

endmodule // nrg_step_gen

// >>> src/nrg_down_timer.sv
`timescale 1ns/1ps

// ********************************************************************
// 16-bit step counter, at most one expiry pulse per start
// ********************************************************************
module nrg_down_timer (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        start_i,
    input  wire logic        stop_i,
    input  wire logic [15:0] value_i,
    input  wire logic        step_i,
    output logic             running_o,
    output logic             expire_o
);

    logic [15:0] count;

    // a zero value never starts; a start while running reloads
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            count     <= 16'h0000;
            running_o <= 1'b0;
            expire_o  <= 1'b0;
        end else begin
            expire_o <= 1'b0;
            if (start_i && value_i != 16'h0000) begin
                count     <= value_i;
                running_o <= 1'b1;
            end else if (stop_i) begin
                running_o <= 1'b0;
            end else if (running_o && step_i) begin
                if (count == 16'h0001) begin
                    running_o <= 1'b0;
                    expire_o  <= 1'b1;
                end
                count <= count - 16'h0001;
            end
        end
    end

endmodule // nrg_down_timer

// >>> tb/nrg_timers_asserts.sv
`timescale 1ns/1ps
`include "nrg_map.svh"
// ****************
// timer checker
// ****************
module nrg_timers_asserts (
    input wire logic              clk_i,
    input wire logic              rst_i,
    input wire logic [7:0]        adr_i,
    input wire logic [31:0]       dat_i,
    input wire logic [31:0]       dat_o,
    input wire logic              we_i,
    input wire logic [3:0]        sel_i,
    input wire logic              cyc_i,
    input wire logic              stb_i,
    input wire logic              ack_o,
    input wire logic              carrier_tick_i,
    input wire nrg_pkg::nrg_evt_t evt_i,
    input wire logic              irq_o,
    input wire logic              field_off_o,
    input wire logic              nrt_running_o,
    input wire logic              gpt_running_o
);
    logic [15:0] nrt_val;
    logic [7:0]  ctrl;
    logic        nfc;
    logic        bus;
    logic        wr;
    logic        dflt;
    assign bus = cyc_i && stb_i;
    assign wr = bus && ack_o && we_i && sel_i[0];
    assign dflt = wr && adr_i[7:2] == `NRG_IDX_COMMAND && dat_i[2];
    // mirror of written settings, so rules on them can be seen at the ports
    always_ff @(posedge clk_i) begin
        if (rst_i || dflt) begin
            nrt_val <= 16'h0000;
            ctrl <= 8'h00;
            nfc <= 1'b0;
        end else if (wr) begin
            case (adr_i[7:2])
                `NRG_IDX_NRT_HIGH: nrt_val[15:8] <= dat_i[7:0];
                `NRG_IDX_NRT_LOW: nrt_val[7:0] <= dat_i[7:0];
                `NRG_IDX_TIMER_CTRL: ctrl <= dat_i[7:0];
                `NRG_IDX_MODE: nfc <= dat_i[0];
                default: ;
            endcase
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_ack_follows: assert property (bus && !ack_o |=> ack_o)
        else $error("ack missing");
    chk_ack_single: assert property (ack_o |=> !ack_o)
        else $error("ack too long");
    chk_read_upper: assert property (ack_o |-> dat_o[31:8] == 24'h00_0000)
        else $error("upper read bits set");
    chk_zero_idle: assert property (
        nrt_val == 16'h0000 && !nrt_running_o && !bus
        && (evt_i.tx_end || evt_i.tx_off) |=> !nrt_running_o)
        else $error("zero value started");
    chk_field_wait: assert property (
        nfc && !evt_i.ext_field && evt_i.tx_end && !nrt_running_o && !bus
        |=> !nrt_running_o)
        else $error("started without field");
    chk_rx_stop: assert property (
        nrt_running_o && evt_i.rx_start && !ctrl[1] && !bus
        && !evt_i.tx_end && !evt_i.tx_off |=> !nrt_running_o)
        else $error("rx start did not stop");
    chk_set_default: assert property (
        dflt |=> !nrt_running_o && !gpt_running_o && !irq_o)
        else $error("default left state");
    chk_gpt_no_trig: assert property (
        (ctrl[7:5] == 3'h0 || ctrl[7]) && !gpt_running_o && !bus
        |=> !gpt_running_o)
        else $error("untriggered start");
    chk_field_trig: assert property (
        field_off_o |-> ctrl[7:5] == 3'h3)
        else $error("field off, wrong trigger");
    chk_field_once: assert property (
        field_off_o |=> !field_off_o)
        else $error("field off too long");
endmodule // nrg_timers_asserts

bind nrg_timers nrg_timers_asserts i_chk (
    .clk_i, .rst_i, .adr_i, .dat_i, .dat_o, .we_i, .sel_i, .cyc_i, .stb_i,
    .ack_o, .carrier_tick_i, .evt_i, .irq_o, .field_off_o, .nrt_running_o,
    .gpt_running_o
);

// >>> tb/tb_top.sv
`timescale 1ns/1ps
`include "nrg_map.svh"
// ****************
// timer bench
// ****************
module tb_top;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic [7:0]  adr = 8'h00;
    logic [31:0] dat = 32'h0000_0000;
    logic        we = 1'b0;
    logic        cyc = 1'b0;
    logic        tick = 1'b0;
    logic [2:0]  ph = 3'h0;
    logic [3:0]  ev4 = 4'h0;
    logic        fld = 1'b0;
    logic        arm = 1'b0;
    logic        irq_q = 1'b0;
    logic [15:0] seed = 16'h5cf7;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        irq_o;
    logic        fof;
    logic        nrt_run;
    logic        gpt_run;
    int          tcnt = 0;
    int          fields = 0;
    int          miscompares = 0;
    int          checked = 0;
    logic [7:0]  exp_rd[$];
    int          exp_tk[$];
    logic [3:0]  codes[3] = '{4'h1, 4'h2, 4'h8};
    logic [5:0]  regs[5] = '{`NRG_IDX_NRT_HIGH, `NRG_IDX_NRT_LOW,
        `NRG_IDX_TIMER_CTRL, `NRG_IDX_GPT_HIGH, `NRG_IDX_GPT_LOW};

    nrg_timers i_dut (
        .clk_i(clk_i), .rst_i(rst_i), .adr_i(adr), .dat_i(dat),
        .dat_o(dat_o), .we_i(we), .sel_i(4'hf), .cyc_i(cyc), .stb_i(cyc),
        .ack_o(ack_o), .carrier_tick_i(tick),
        .evt_i(nrg_pkg::nrg_evt_t'({ev4, fld})), .irq_o(irq_o),
        .field_off_o(fof), .nrt_running_o(nrt_run), .gpt_running_o(gpt_run)
    );

    always #20 clk_i = ~clk_i;
    // carrier every fifth cycle leaves slack for the expiry latency
    always @(posedge clk_i) begin
        ph <= (ph == 3'h4) ? 3'h0 : ph + 3'h1;
        tick <= (ph == 3'h4);
    end
    // result watcher: takes the oldest note whenever a result appears
    always @(posedge clk_i) begin
        tcnt <= arm ? 0 : tcnt + int'(tick);
        irq_q <= irq_o;
        if (fof === 1'b1) fields <= fields + 1;
        if (cyc && !we && ack_o === 1'b1 && exp_rd.size() != 0)
            check("read_data", dat_o, {24'h00_0000, exp_rd.pop_front()});
        if (irq_o === 1'b1 && irq_q !== 1'b1 && exp_tk.size() != 0)
            check("expiry_ticks", 32'(tcnt), 32'(exp_tk.pop_front()));
    end

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
    task automatic check(input string nm, input logic [31:0] seen, exp);
        checked++;
        if (seen !== exp) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wb(input logic [5:0] i, input logic w, input logic [7:0] d,
                      input logic a);
        int n;
        n = 0;
        @(posedge clk_i);
        cyc <= 1'b1;
        adr <= {i, 2'b00};
        we <= w;
        dat <= {24'h00_0000, d};
        arm <= a;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        cyc <= 1'b0;
        we <= 1'b0;
        arm <= 1'b0;
    endtask
    task automatic rd(input logic [5:0] i, input logic [7:0] e);
        exp_rd.push_back(e);
        wb(i, 1'b0, 8'h00, 1'b0);
    endtask
    task automatic ev(input logic [3:0] c);
        @(posedge clk_i);
        ev4 <= c;
        arm <= 1'b1;
        @(posedge clk_i);
        ev4 <= 4'h0;
        arm <= 1'b0;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask
    task automatic wait_pop(input string nm);
        int n;
        n = 0;
        while (exp_tk.size() != 0 && n < 30000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 30000) miscompares++;
        $display("test %s done", nm);
    endtask
    task automatic give_verdict();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    initial begin
        repeat (60000) @(posedge clk_i);
        miscompares++;
        give_verdict();
    end

    initial begin
        logic [15:0] nv;
        logic        e;
        repeat (8) @(posedge clk_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) rd(regs[i], 8'h00);
        wb(6'h02, 1'b1, 8'hff, 1'b0);
        rd(6'h02, 8'h00);
        for (int i = 0; i < 5; i++) begin
            seed = lfsr(seed);
            wb(regs[i], 1'b1, seed[7:0], 1'b0);
            rd(regs[i], (i == 2) ? seed[7:0] & 8'he3 : seed[7:0]);
        end
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h04, 1'b0);
        for (int i = 0; i < 5; i++) rd(regs[i], 8'h00);
        wait_pop("registers");
        seed = lfsr(seed);
        nv = {14'h0000, seed[1:0]} + 16'h0001;
        wb(`NRG_IDX_NRT_LOW, 1'b1, nv[7:0], 1'b0);
        exp_tk.push_back(64 * int'(nv));
        ev(4'h8);
        wait_pop("nrt_step");
        rd(`NRG_IDX_IRQ_STATUS, 8'h40);
        wb(`NRG_IDX_IRQ_STATUS, 1'b1, 8'h60, 1'b0);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h01, 1'b0);
        wb(`NRG_IDX_NRT_LOW, 1'b1, 8'h01, 1'b0);
        exp_tk.push_back(4096);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h01, 1'b1);
        wait_pop("nrt_long");
        wb(`NRG_IDX_IRQ_STATUS, 1'b1, 8'h40, 1'b0);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h00, 1'b0);
        wb(`NRG_IDX_NRT_LOW, 1'b1, 8'h02, 1'b0);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h01, 1'b0);
        settle(200);
        exp_tk.push_back(128);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h01, 1'b1);
        wait_pop("restart");
        wb(`NRG_IDX_IRQ_STATUS, 1'b1, 8'h40, 1'b0);
        ev(4'h8);
        settle(20);
        ev(4'h2);
        settle(2);
        check("nrt_rx_stop", 32'(nrt_run), 32'h0000_0000);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h02, 1'b0);
        ev(4'h8);
        settle(5);
        ev(4'h2);
        settle(2);
        check("nrt_pay_keep", 32'(nrt_run), 32'h0000_0001);
        ev(4'h1);
        settle(2);
        check("nrt_pay_stop", 32'(nrt_run), 32'h0000_0000);
        settle(700);
        check("irq_after_stop", 32'(irq_o), 32'h0000_0000);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h00, 1'b0);
        wb(`NRG_IDX_NRT_LOW, 1'b1, 8'h00, 1'b0);
        ev(4'h8);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h01, 1'b0);
        settle(3);
        check("nrt_zero", 32'(nrt_run), 32'h0000_0000);
        wb(`NRG_IDX_NRT_LOW, 1'b1, 8'h02, 1'b0);
        wb(`NRG_IDX_MODE, 1'b1, 8'h01, 1'b0);
        ev(4'h8);
        settle(20);
        check("nrt_no_field", 32'(nrt_run), 32'h0000_0000);
        rd(`NRG_IDX_STATE, 8'h02);
        @(posedge clk_i);
        fld <= 1'b1;
        settle(3);
        check("nrt_field", 32'(nrt_run), 32'h0000_0001);
        ev(4'h2);
        wb(`NRG_IDX_MODE, 1'b1, 8'h02, 1'b0);
        ev(4'h8);
        settle(3);
        check("nrt_p2p_txend", 32'(nrt_run), 32'h0000_0000);
        exp_tk.push_back(128);
        ev(4'h4);
        wait_pop("nrt_modes");
        for (int t = 0; t < 8; t++) begin
            for (int k = 0; k < 3; k++) begin
                wb(`NRG_IDX_COMMAND, 1'b1, 8'h04, 1'b0);
                wb(`NRG_IDX_GPT_HIGH, 1'b1, 8'h01, 1'b0);
                wb(`NRG_IDX_MODE, 1'b1, 8'h01, 1'b0);
                wb(`NRG_IDX_TIMER_CTRL, 1'b1, {t[2:0], 5'h00}, 1'b0);
                e = (t == k + 1);
                ev(codes[k]);
                settle(2);
                check("gpt_trigger", 32'(gpt_run), 32'(e));
            end
        end
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h04, 1'b0);
        wb(`NRG_IDX_MODE, 1'b1, 8'h01, 1'b0);
        wb(`NRG_IDX_GPT_LOW, 1'b1, nv[7:0], 1'b0);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h60, 1'b0);
        exp_tk.push_back(8 * int'(nv));
        ev(4'h8);
        wait_pop("gpt_field");
        settle(3);
        check("field_off", 32'(fields), 32'h0000_0001);
        rd(`NRG_IDX_IRQ_STATUS, 8'h20);
        wb(`NRG_IDX_IRQ_STATUS, 1'b1, 8'h20, 1'b0);
        wb(`NRG_IDX_TIMER_CTRL, 1'b1, 8'h00, 1'b0);
        exp_tk.push_back(8 * int'(nv));
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h02, 1'b1);
        wait_pop("gpt_command");
        settle(3);
        check("field_off_idle", 32'(fields), 32'h0000_0001);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h04, 1'b0);
        wb(`NRG_IDX_IRQ_MASK, 1'b1, 8'h40, 1'b0);
        wb(`NRG_IDX_NRT_LOW, 1'b1, 8'h01, 1'b0);
        wb(`NRG_IDX_COMMAND, 1'b1, 8'h01, 1'b0);
        settle(340);
        check("irq_masked", 32'(irq_o), 32'h0000_0000);
        rd(`NRG_IDX_IRQ_STATUS, 8'h40);
        wb(`NRG_IDX_IRQ_MASK, 1'b1, 8'h00, 1'b0);
        settle(1);
        check("irq_unmasked", 32'(irq_o), 32'h0000_0001);
        wb(`NRG_IDX_IRQ_STATUS, 1'b1, 8'h40, 1'b0);
        settle(1);
        check("irq_cleared", 32'(irq_o), 32'h0000_0000);
        rd(`NRG_IDX_IRQ_STATUS, 8'h00);
        wait_pop("interrupt");
        give_verdict();
    end
endmodule // tb_top
